// File: mie_exec_core.v
// What this block does
// - add-with-carry sums work register, data byte, carry; five flags updated
// - plain add of data byte or immediate, no carry in; five flags updated
// - AND and OR with data byte or immediate; only zero flag changes
// - call pushes pc plus 1, loads target, two cycles, flags unchanged
// - byte clear writes zero; bit clear zeroes bit i; no flags
// - watchdog clear resets counter and clears expiry and sleep flags
// - complement inverts data byte to memory or work register; zero flag
// - decimal adjust adds 6 per nibble over 9 or carry; only carry changes
// - decrement data byte to memory or work register; zero flag updated
// - increment data byte to memory or work register; memory form sets zero
// - power-down halts, stops clock, clears watchdog and prescaler, sets sleep
// - jump loads target with dummy cycle, two cycles, no flags
// - moves between data byte, immediate and work register, no flags
// - no-operation changes nothing and proceeds to the next instruction
// - return pops pc; immediate variant also loads work register
// - interrupt return pops pc and sets global interrupt enable
// - rotate left moves bit 7 to bit 0, writes back, no flags
// - extended instruction writing program counter low takes three cycles
// file holds the execute datapath; assumes an outside fetch unit presents one
// opcode with its operands and data byte, and an outside memory takes writes
`timescale 1ns/100ps
`include "mie_consts.vh"
module mie_exec_core #(
  parameter PC_W = 12,
  parameter STACK_DEPTH = 8
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  input wire wake_in,
  input wire issue_in,
  input wire [4:0] opcode_in,
  input wire to_mem_in,
  input wire [7:0] data_in,
  input wire [7:0] imm_in,
  input wire [2:0] bit_sel_in,
  input wire [11:0] target_in,
  input wire irq_pending_in,
  output reg busy_out,
  output reg done_out,
  output reg mem_we_out,
  output reg [7:0] mem_wdata_out,
  output reg [7:0] work_register_out,
  output reg [11:0] pc_out,
  output reg carry_flag_out,
  output reg zero_flag_out,
  output reg half_carry_flag_out,
  output reg signed_wrap_flag_out,
  output reg signed_carry_flag_out,
  output reg watchdog_expiry_flag_out,
  output reg sleep_entered_flag_out,
  output reg global_irq_enable_out,
  output reg watchdog_clear_out,
  output reg sys_clk_stop_out,
  output reg irq_service_out
);
  localparam ST_RUN = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SLEEP = 2'h2;

  reg [1:0] state_r;
  reg [1:0] cyc_left_r;
  reg [11:0] stack_r [0:STACK_DEPTH-1];
  reg [2:0] sp_r;
  integer k;

  wire take = clk_en_in && issue_in && (state_r == ST_RUN);
  wire use_imm = (opcode_in == `MIE_OP_ADDI);
  wire add_cin = (opcode_in == `MIE_OP_ADC) ? carry_flag_out : 1'b0;
  wire [7:0] add_b = use_imm ? imm_in : data_in;
  wire [7:0] add_sum;
  wire add_c;
  wire add_hc;
  wire add_ov;
  wire add_sc;
  wire add_z;

  mie_add_flags u_add (
    .a_in(work_register_out),
    .b_in(add_b),
    .cin_in(add_cin),
    .sum_out(add_sum),
    .carry_out(add_c),
    .half_carry_out(add_hc),
    .signed_wrap_out(add_ov),
    .signed_carry_out(add_sc),
    .zero_out(add_z)
  );

  // decimal adjust terms
  wire lo_adj = (work_register_out[3:0] > `MIE_NIB_MAX) || half_carry_flag_out;
  wire hi_adj = (work_register_out[7:4] > `MIE_NIB_MAX) || carry_flag_out;
  wire [8:0] daa_sum = {1'b0, work_register_out}
                       + {1'b0, lo_adj ? `MIE_ADJ_LO : `MIE_BYTE_ZERO}
                       + {1'b0, hi_adj ? `MIE_ADJ_HI : `MIE_BYTE_ZERO};

  reg [7:0] res;
  reg wr_mem;
  reg wr_acc;
  reg upd_z;
  reg upd_arith;
  reg [1:0] cycles;
  reg [11:0] pc_nxt;
  reg push;
  reg pop;

  always @* begin
    res = `MIE_BYTE_ZERO;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    upd_arith = 1'b0;
    cycles = `MIE_CYC_ONE;
    pc_nxt = pc_out + `MIE_PC_ONE;
    push = 1'b0;
    pop = 1'b0;
    case (opcode_in)
      `MIE_OP_ADC, `MIE_OP_ADD, `MIE_OP_ADDI: begin
        res = add_sum;
        upd_arith = 1'b1;
        wr_mem = to_mem_in && !use_imm;
        wr_acc = !(to_mem_in && !use_imm);
      end
      `MIE_OP_AND, `MIE_OP_ANDI: begin
        res = work_register_out & ((opcode_in == `MIE_OP_ANDI) ? imm_in : data_in);
        upd_z = 1'b1;
        wr_mem = to_mem_in && (opcode_in == `MIE_OP_AND);
        wr_acc = !wr_mem;
      end
      `MIE_OP_OR, `MIE_OP_ORI: begin
        res = work_register_out | ((opcode_in == `MIE_OP_ORI) ? imm_in : data_in);
        upd_z = 1'b1;
        wr_mem = to_mem_in && (opcode_in == `MIE_OP_OR);
        wr_acc = !wr_mem;
      end
      `MIE_OP_CALL: begin
        push = 1'b1;
        pc_nxt = target_in;
        cycles = `MIE_CYC_TWO;
      end
      `MIE_OP_CLR: begin
        res = `MIE_BYTE_ZERO;
        wr_mem = 1'b1;
      end
      `MIE_OP_CLRB: begin
        res = data_in & ~(`MIE_BYTE_ONE << bit_sel_in);
        wr_mem = 1'b1;
      end
      `MIE_OP_CPL: begin
        res = ~data_in;
        upd_z = 1'b1;
        wr_mem = to_mem_in;
        wr_acc = !to_mem_in;
      end
      `MIE_OP_DAA: begin
        res = daa_sum[7:0];
        wr_mem = 1'b1;
      end
      `MIE_OP_DEC: begin
        res = data_in - `MIE_BYTE_ONE;
        upd_z = 1'b1;
        wr_mem = to_mem_in;
        wr_acc = !to_mem_in;
      end
      `MIE_OP_INC: begin
        res = data_in + `MIE_BYTE_ONE;
        upd_z = to_mem_in;
        wr_mem = to_mem_in;
        wr_acc = !to_mem_in;
      end
      `MIE_OP_JMP: begin
        pc_nxt = target_in;
        cycles = `MIE_CYC_TWO;
      end
      `MIE_OP_MOVAM: begin
        res = data_in;
        wr_acc = 1'b1;
      end
      `MIE_OP_MOVAI: begin
        res = imm_in;
        wr_acc = 1'b1;
      end
      `MIE_OP_MOVMA: begin
        res = work_register_out;
        wr_mem = 1'b1;
      end
      `MIE_OP_RET, `MIE_OP_RETI, `MIE_OP_RETI_IMM: begin
        pop = 1'b1;
        pc_nxt = stack_r[sp_r - `MIE_SP_ONE];
        res = imm_in;
        wr_acc = (opcode_in == `MIE_OP_RETI_IMM);
        cycles = `MIE_CYC_TWO;
      end
      `MIE_OP_RL: begin
        res = {data_in[`MIE_BIT_MSB-1:0], data_in[`MIE_BIT_MSB]};
        wr_mem = 1'b1;
      end
      `MIE_OP_PCLW: begin
        // extended write to the program counter low byte
        pc_nxt = {pc_out[11:8], work_register_out};
        cycles = `MIE_CYC_THREE;
      end
      default: begin
        res = `MIE_BYTE_ZERO;
      end
    endcase
  end

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_RUN;
      cyc_left_r <= `MIE_CYC_ONE;
      sp_r <= `MIE_SP_ZERO;
      for (k = 0; k < STACK_DEPTH; k = k + 1) begin
        stack_r[k] <= `MIE_PC_RESET;
      end
      busy_out <= 1'b0;
      done_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_wdata_out <= `MIE_BYTE_ZERO;
      work_register_out <= `MIE_BYTE_ZERO;
      pc_out <= `MIE_PC_RESET;
      carry_flag_out <= 1'b0;
      zero_flag_out <= 1'b0;
      half_carry_flag_out <= 1'b0;
      signed_wrap_flag_out <= 1'b0;
      signed_carry_flag_out <= 1'b0;
      watchdog_expiry_flag_out <= 1'b0;
      sleep_entered_flag_out <= 1'b0;
      global_irq_enable_out <= 1'b0;
      watchdog_clear_out <= 1'b0;
      sys_clk_stop_out <= 1'b0;
      irq_service_out <= 1'b0;
    end else if (clk_en_in) begin
      done_out <= 1'b0;
      mem_we_out <= 1'b0;
      watchdog_clear_out <= 1'b0;
      irq_service_out <= 1'b0;
      case (state_r)
        ST_RUN: begin
          if (take) begin
            pc_out <= pc_nxt;
            if (wr_mem) begin
              mem_we_out <= 1'b1;
              mem_wdata_out <= res;
            end
            if (wr_acc) begin
              work_register_out <= res;
            end
            if (upd_z || upd_arith) begin
              zero_flag_out <= (res == `MIE_BYTE_ZERO);
            end
            if (upd_arith) begin
              carry_flag_out <= add_c;
              half_carry_flag_out <= add_hc;
              signed_wrap_flag_out <= add_ov;
              signed_carry_flag_out <= add_sc;
            end
            if (opcode_in == `MIE_OP_DAA) begin
              carry_flag_out <= carry_flag_out | daa_sum[8];
            end
            if (push) begin
              stack_r[sp_r] <= pc_out + `MIE_PC_ONE;
              sp_r <= sp_r + `MIE_SP_ONE;
            end
            if (pop) begin
              sp_r <= sp_r - `MIE_SP_ONE;
            end
            // only the interrupt return re-enables; return with immediate leaves it alone
            if (opcode_in == `MIE_OP_RETI) begin
              global_irq_enable_out <= 1'b1;
              irq_service_out <= irq_pending_in;
            end
            if (opcode_in == `MIE_OP_CLRWD) begin
              watchdog_clear_out <= 1'b1;
              watchdog_expiry_flag_out <= 1'b0;
              sleep_entered_flag_out <= 1'b0;
            end
            if (opcode_in == `MIE_OP_HALT) begin
              watchdog_clear_out <= 1'b1;
              watchdog_expiry_flag_out <= 1'b0;
              sleep_entered_flag_out <= 1'b1;
              sys_clk_stop_out <= 1'b1;
              busy_out <= 1'b1;
              state_r <= ST_SLEEP;
            end else if (cycles != `MIE_CYC_ONE) begin
              busy_out <= 1'b1;
              cyc_left_r <= cycles - `MIE_CYC_ONE;
              state_r <= ST_WAIT;
            end else begin
              done_out <= 1'b1;
            end
          end
        end
        ST_WAIT: begin
          // dummy cycles while the new address loads
          if (cyc_left_r == `MIE_CYC_ONE) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state_r <= ST_RUN;
          end else begin
            cyc_left_r <= cyc_left_r - `MIE_CYC_ONE;
          end
        end
        ST_SLEEP: begin
          if (wake_in) begin
            sys_clk_stop_out <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end
endmodule

// File: mie_consts.vh
// constants for the instruction execute block
// included by the execute core, its monitor and its bench
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH
`define MIE_OP_NOP 5'h00
`define MIE_OP_ADC 5'h01
`define MIE_OP_ADD 5'h02
`define MIE_OP_ADDI 5'h03
`define MIE_OP_AND 5'h04
`define MIE_OP_ANDI 5'h05
`define MIE_OP_OR 5'h06
`define MIE_OP_ORI 5'h07
`define MIE_OP_CALL 5'h08
`define MIE_OP_CLR 5'h09
`define MIE_OP_CLRB 5'h0A
`define MIE_OP_CLRWD 5'h0B
`define MIE_OP_CPL 5'h0C
`define MIE_OP_DAA 5'h0D
`define MIE_OP_DEC 5'h0E
`define MIE_OP_INC 5'h0F
`define MIE_OP_HALT 5'h10
`define MIE_OP_JMP 5'h11
`define MIE_OP_MOVAM 5'h12
`define MIE_OP_MOVAI 5'h13
`define MIE_OP_MOVMA 5'h14
`define MIE_OP_RET 5'h15
`define MIE_OP_RETI 5'h16
`define MIE_OP_RETI_IMM 5'h17
`define MIE_OP_RL 5'h18
`define MIE_OP_PCLW 5'h19
`define MIE_BYTE_ZERO 8'h00
`define MIE_BYTE_ONE 8'h01
`define MIE_NIB_MAX 4'h9
`define MIE_ADJ_LO 8'h06
`define MIE_ADJ_HI 8'h60
`define MIE_PC_ONE 12'h001
`define MIE_PC_RESET 12'h000
`define MIE_CYC_ONE 2'h1
`define MIE_CYC_TWO 2'h2
`define MIE_CYC_THREE 2'h3
`define MIE_SP_ZERO 3'h0
`define MIE_SP_ONE 3'h1
`define MIE_BIT_MSB 7
`endif

// File: mie_add_flags.v
// eight-bit adder with carry-in and the five arithmetic flags
// purely combinational; used by the execute core
`timescale 1ns/100ps
module mie_add_flags (
  input wire [7:0] a_in,
  input wire [7:0] b_in,
  input wire cin_in,
  output wire [7:0] sum_out,
  output wire carry_out,
  output wire half_carry_out,
  output wire signed_wrap_out,
  output wire signed_carry_out,
  output wire zero_out
);
  wire [8:0] full;
  wire [4:0] low;
  wire c6;
  assign full = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin_in};
  assign low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin_in};
  assign c6 = full[7] ^ a_in[7] ^ b_in[7];
  assign sum_out = full[7:0];
  assign carry_out = full[8];
  assign half_carry_out = low[4];
  assign signed_wrap_out = c6 ^ full[8];
  // sign of the true nine-bit signed sum
  assign signed_carry_out = a_in[7] ^ b_in[7] ^ full[8];
  assign zero_out = (full[7:0] == `MIE_BYTE_ZERO);
endmodule

// File: mie_exec_core_monitor.sv
// assertion checker for the instruction execute core
// assumes it is bound to mie_exec_core and sees only its ports
`timescale 1ns/100ps
`include "mie_consts.vh"
module mie_exec_core_monitor (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  input wire issue_in,
  input wire [4:0] opcode_in,
  input wire [7:0] data_in,
  input wire [11:0] target_in,
  input wire busy_out,
  input wire done_out,
  input wire mem_we_out,
  input wire [7:0] mem_wdata_out,
  input wire [11:0] pc_out,
  input wire carry_flag_out,
  input wire watchdog_expiry_flag_out,
  input wire sleep_entered_flag_out,
  input wire global_irq_enable_out,
  input wire watchdog_clear_out,
  input wire sys_clk_stop_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire take_w = clk_en_in && issue_in && !busy_out;
  sequence s_two;
    busy_out ##1 done_out && !busy_out;
  endsequence
  sequence s_three;
    busy_out[*2] ##1 done_out && !busy_out;
  endsequence
  chk_jmp_target: assert property (take_w && opcode_in == `MIE_OP_JMP |=>
    pc_out == $past(target_in) ##0 s_two) else $error("jump target or length wrong");
  chk_call_target: assert property (take_w && opcode_in == `MIE_OP_CALL |=>
    s_two ##0 pc_out == $past(target_in, 2)) else $error("call target or length wrong");
  chk_pcl_three: assert property (take_w && opcode_in == `MIE_OP_PCLW |=>
    s_three) else $error("pc low write not three cycles");
  chk_one_cycle: assert property (take_w && opcode_in <= `MIE_OP_ORI |=>
    done_out && !busy_out) else $error("single cycle op not done");
  chk_halt_sleep: assert property (take_w && opcode_in == `MIE_OP_HALT |=>
    sleep_entered_flag_out && !watchdog_expiry_flag_out && sys_clk_stop_out && busy_out)
    else $error("power down entry wrong");
  chk_wdt_clear: assert property (take_w && opcode_in == `MIE_OP_CLRWD |=>
    watchdog_clear_out && !watchdog_expiry_flag_out && !sleep_entered_flag_out)
    else $error("watchdog clear wrong");
  chk_reti_enable: assert property (take_w && opcode_in == `MIE_OP_RETI |->
    ##2 done_out && global_irq_enable_out) else $error("irq enable not set");
  chk_clr_zero: assert property (take_w && opcode_in == `MIE_OP_CLR |=>
    mem_we_out && mem_wdata_out == 8'h00) else $error("byte clear wrong");
  chk_rl_rotate: assert property (take_w && opcode_in == `MIE_OP_RL |=> mem_we_out &&
    mem_wdata_out == {$past(data_in[6:0]), $past(data_in[7])}) else $error("rotate wrong");
  chk_logic_carry: assert property (take_w && opcode_in >= `MIE_OP_AND &&
    opcode_in <= `MIE_OP_ORI |=> $stable(carry_flag_out)) else $error("logic op moved carry");
endmodule
bind mie_exec_core mie_exec_core_monitor chk_u (.*);

// File: mie_exec_core_bench.sv
// self-checking bench for the instruction execute core
// assumes the core and its adder helper are compiled alongside
`timescale 1ns/100ps
`include "mie_consts.vh"
module mie_exec_core_bench;
  reg clk = 0, rst_n = 0, wake = 0, iss = 0, tm = 0, irq = 0, irq_seen = 0, ce = 1;
  reg [4:0] opc = 0;
  reg [7:0] dat = 0, imm = 0;
  reg [2:0] bs = 0;
  reg [11:0] tgt = 0;
  wire busy, done, we, cf, zf, hf, vf, sf, tof, sleep_entered_flag, gie, wdc, stop, irqs;
  wire [7:0] wd, wr;
  wire [11:0] pc;
  integer fail_count = 0, total_checks = 0, n;
  mie_exec_core dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(ce), .wake_in(wake),
    .issue_in(iss), .opcode_in(opc), .to_mem_in(tm), .data_in(dat), .imm_in(imm),
    .bit_sel_in(bs), .target_in(tgt), .irq_pending_in(irq), .busy_out(busy), .done_out(done),
    .mem_we_out(we), .mem_wdata_out(wd), .work_register_out(wr), .pc_out(pc),
    .carry_flag_out(cf), .zero_flag_out(zf), .half_carry_flag_out(hf),
    .signed_wrap_flag_out(vf), .signed_carry_flag_out(sf), .watchdog_expiry_flag_out(tof),
    .sleep_entered_flag_out(sleep_entered_flag), .global_irq_enable_out(gie), .watchdog_clear_out(wdc),
    .sys_clk_stop_out(stop), .irq_service_out(irqs));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (irqs === 1'b1) irq_seen <= 1'b1;
  task ck(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // idle one edge, issue one op, return just after the edge that took it
  task op(input [4:0] o, input m, input [7:0] d, input [7:0] i, input [11:0] t);
    begin
      @(posedge clk);
      #1 opc = o;
      tm = m;
      dat = d;
      imm = i;
      tgt = t;
      iss = 1'b1;
      @(posedge clk);
      #1 iss = 1'b0;
    end
  endtask
  task wt;
    begin
      n = 1;
      while (done !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      ck(done, 1'b1);
    end
  endtask
  task t_arith;
    begin
      op(`MIE_OP_MOVAI, 0, 0, 8'h7F, 0); ck(wr, 8'h7F);
      op(`MIE_OP_ADD, 0, 8'h01, 0, 0); ck({done, wr, vf, hf, cf, zf, sf}, 14'h3018);
      op(`MIE_OP_ADDI, 0, 0, 8'h80, 0); ck({wr, vf, hf, cf, zf, sf}, 13'h0017);
      op(`MIE_OP_ADC, 1, 8'h05, 0, 0); ck({we, wd, wr, vf, hf, cf, zf, sf}, 22'h20C000);
      op(`MIE_OP_MOVAI, 0, 0, 8'h09, 0);
      op(`MIE_OP_ADD, 0, 8'h08, 0, 0); ck({wr, hf, cf}, 10'h046);
      op(`MIE_OP_DAA, 0, 0, 0, 0); ck({we, wd, cf}, 10'h22E);
      op(`MIE_OP_MOVAI, 0, 0, 8'h99, 0);
      op(`MIE_OP_ADD, 0, 8'h99, 0, 0); ck({wr, hf, cf}, 10'h0CB);
      op(`MIE_OP_DAA, 0, 0, 0, 0); ck({wd, wr, cf}, 17'h13065);
    end
  endtask
  task t_logic;
    begin
      op(`MIE_OP_MOVAI, 0, 0, 8'hF0, 0);
      op(`MIE_OP_AND, 0, 8'h0F, 0, 0); ck({wr, zf, cf, hf}, 11'h007);
      op(`MIE_OP_ORI, 0, 0, 8'h3C, 0); ck({wr, zf}, 9'h078);
      op(`MIE_OP_ANDI, 0, 0, 8'hFF, 0); ck({wr, zf}, 9'h078);
      op(`MIE_OP_OR, 1, 8'h01, 0, 0); ck({we, wd, wr}, 17'h13D3C);
    end
  endtask
  task t_unary;
    begin
      op(`MIE_OP_CPL, 1, 8'hA5, 0, 0); ck({we, wd, zf}, 10'h2B4);
      op(`MIE_OP_CPL, 0, 8'hFF, 0, 0); ck({we, wr, zf}, 10'h001);
      op(`MIE_OP_DEC, 1, 8'h00, 0, 0); ck({we, wd, zf}, 10'h3FE);
      op(`MIE_OP_INC, 1, 8'hFF, 0, 0); ck({wd, zf}, 9'h001);
      op(`MIE_OP_INC, 0, 8'h7F, 0, 0); ck({we, wr}, 9'h080);
      op(`MIE_OP_CLR, 0, 8'h55, 0, 0); ck({we, wd, zf}, 10'h201);
      bs = 3'h3;
      op(`MIE_OP_CLRB, 0, 8'hFF, 0, 0); ck({we, wd}, 9'h1F7);
      op(`MIE_OP_RL, 0, 8'h81, 0, 0); ck({we, wd}, 9'h103);
      op(`MIE_OP_MOVAM, 0, 8'h9C, 0, 0); ck({wr, zf}, 9'h139);
      op(`MIE_OP_MOVMA, 0, 0, 0, 0); ck({we, wd}, 9'h19C);
      op(`MIE_OP_NOP, 0, 0, 0, 0); ck({done, we, wr, cf, zf}, 12'hA73);
    end
  endtask
  task t_flow;
    begin
      op(`MIE_OP_JMP, 0, 0, 0, 12'h123); ck({busy, pc}, 13'h1123); wt; ck(n, 2);
      op(`MIE_OP_CALL, 0, 0, 0, 12'h456); wt; ck({n[3:0], pc}, 16'h2456);
      op(`MIE_OP_RET, 0, 0, 0, 0); wt; ck(pc, 12'h124);
      op(`MIE_OP_CALL, 0, 0, 0, 12'h200); wt;
      op(`MIE_OP_RETI_IMM, 0, 0, 8'hA5, 0); wt; ck({gie, wr, pc}, 21'h0A5125);
      irq = 1'b1;
      op(`MIE_OP_CALL, 0, 0, 0, 12'h300); wt;
      op(`MIE_OP_RETI, 0, 0, 0, 0); wt; #10 ck({gie, irq_seen, pc}, 14'h3126);
      irq = 1'b0;
      op(`MIE_OP_PCLW, 0, 0, 0, 0); wt; ck({n[3:0], pc[7:0]}, 12'h3A5);
    end
  endtask
  task t_power;
    begin
      op(`MIE_OP_CLRWD, 0, 0, 0, 0); ck({wdc, tof, sleep_entered_flag}, 3'h4);
      op(`MIE_OP_HALT, 0, 0, 0, 0); ck({sleep_entered_flag, tof, stop, busy}, 4'hB);
      op(`MIE_OP_MOVAI, 0, 0, 8'h11, 0); ck({wr, busy, stop}, 10'h297);
      wake = 1'b1; wt; wake = 1'b0; ck({stop, sleep_entered_flag, wr}, 10'h1A5);
      op(`MIE_OP_CLRWD, 0, 0, 0, 0); ck({wdc, sleep_entered_flag}, 2'h2);
      // clock enable low: nothing taken, pulses and registers frozen
      ce = 1'b0;
      op(`MIE_OP_MOVAI, 0, 0, 8'h5A, 0); ck({wr, wdc, done}, 10'h297);
      ce = 1'b1;
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #20000 fail_count = fail_count + 1;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    t_arith;
    t_logic;
    t_unary;
    t_flow;
    t_power;
    end_of_test;
  end
endmodule
